// ### src/asp_serial_port.sv
// Device end of the converter serial port: command byte, register writes,
// register and result reads, ready indication on the shared output pin.
// Assumes sclk, cs_n and din come from pins; conv_valid/conv_result come
// from the conversion core on the same clock.
`timescale 1ns/100ps

// Operation
// - Serial clock may pause between bursts; bit position is held across pauses.
// - Transfers happen only while select is low.
// - With select tied low the port still works over three wires.
// - Outside a read, the output line falls when a new conversion result becomes valid.
// - Output bits change on falling serial clock edges, sampled on rising ones.
// - A ready flag in the status register is set at each conversion end.
// - Select high releases the output line; ready flag keeps tracking.
// - Input bits shift in; the word goes to the register the command selected.
// - Each transaction starts with a command byte choosing read or write.
// - A one in the first command bit holds position; zero starts loading.
// - Command bytes arrive most significant bit first, gate bit first.
// - Thirty-two clocked ones on the input reset the whole part.
module asp_serial_port
  import asp_pkg::*;
(
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic         sclk,
  input  wire logic         cs_n,
  input  wire logic         din,
  input  wire logic         conv_valid,
  input  wire logic [23:0]  conv_result,
  output logic              dout,
  output logic              dout_oe_n,
  output logic              ready,
  output asp_pkg::asp_cfg_t cfg,
  output logic              cfg_wr,
  output logic              data_read,
  output logic              part_reset
);
  import asp_pkg::*;

  logic      rst_a_q;
  logic      rst_b_q;
  logic      sclk_s;
  logic      cs_n_s;
  logic      din_s;
  logic      rise;
  logic      fall;
  logic      sel;
  logic      ready_set;
  logic [7:0] cmd;
  asp_regs_t r_q;
  asp_regs_t r_d;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_a_q <= 1'b0;
      rst_b_q <= 1'b0;
    end else begin
      rst_a_q <= 1'b1;
      rst_b_q <= rst_a_q;
    end
  end

  // Serial clock idles high, so it resets high: no false edge follows reset
  asp_sync #(.RST_VAL(1'b1)) u_sync_sclk (
    .clock    (clock),
    .rst_n    (rst_b_q),
    .async_in (sclk),
    .sync_out (sclk_s)
  );

  asp_sync #(.RST_VAL(1'b1)) u_sync_cs (
    .clock    (clock),
    .rst_n    (rst_b_q),
    .async_in (cs_n),
    .sync_out (cs_n_s)
  );

  asp_sync #(.RST_VAL(1'b0)) u_sync_din (
    .clock    (clock),
    .rst_n    (rst_b_q),
    .async_in (din),
    .sync_out (din_s)
  );

  // Edges are found on the synchronised clock, so pauses of any length are harmless
  assign sel  = !cs_n_s;
  assign rise = sel && sclk_s && !r_q.sclk_prev;
  assign fall = sel && !sclk_s && r_q.sclk_prev;
  assign cmd  = {r_q.shreg[6:0], din_s};

  always_comb begin
    r_d           = r_q;
    r_d.sclk_prev = sclk_s;
    r_d.wr_pulse  = 1'b0;
    r_d.rd_done   = 1'b0;
    r_d.part_rst  = 1'b0;
    ready_set     = 1'b0;

    if (conv_valid) begin
      r_d.data  = conv_result;
      ready_set = 1'b1;
    end

    if (!sel) begin
      // Partial frames are dropped so the next select low starts clean
      r_d.st      = ST_CMD;
      r_d.bit_cnt = 5'h00;
      r_d.ones    = 6'h00;
    end else if (rise) begin
      if (din_s) begin
        r_d.ones = (r_q.ones == ONES_RESET) ? ONES_RESET : r_q.ones + 6'h01;
      end else begin
        r_d.ones = 6'h00;
      end

      unique case (r_q.st)
        ST_CMD: begin
          if (r_q.bit_cnt == 5'h00 && din_s) begin
            r_d.bit_cnt = 5'h00;
          end else if (r_q.bit_cnt == LEN_CMD - 5'h01) begin
            r_d.bit_cnt = 5'h00;
            r_d.rs      = cmd[CMD_RS_HI:CMD_RS_LO];
            if (cmd[CMD_DIR_BIT]) begin
              r_d.st = ST_READ;
              unique case (cmd[CMD_RS_HI:CMD_RS_LO])
                RS_STATUS: begin
                  r_d.len   = LEN_STATUS;
                  r_d.shreg = {r_q.ready, 7'h00, 16'h0000};
                end
                RS_MODE: begin
                  r_d.len   = LEN_MODE;
                  r_d.shreg = {r_q.cfg.mode, 8'h00};
                end
                RS_FILTER: begin
                  r_d.len   = LEN_FILTER;
                  r_d.shreg = {r_q.cfg.filter, 16'h0000};
                end
                RS_DATA: begin
                  r_d.len   = LEN_DATA;
                  r_d.shreg = r_q.data;
                end
              endcase
            end else begin
              unique case (cmd[CMD_RS_HI:CMD_RS_LO])
                RS_MODE: begin
                  r_d.st  = ST_WRITE;
                  r_d.len = LEN_MODE;
                end
                RS_FILTER: begin
                  r_d.st  = ST_WRITE;
                  r_d.len = LEN_FILTER;
                end
                // The command write itself is the whole access; data is read only
                default: r_d.st = ST_CMD;
              endcase
            end
          end else begin
            r_d.shreg   = {r_q.shreg[22:0], din_s};
            r_d.bit_cnt = r_q.bit_cnt + 5'h01;
          end
        end
        ST_WRITE: begin
          r_d.shreg   = {r_q.shreg[22:0], din_s};
          r_d.bit_cnt = r_q.bit_cnt + 5'h01;
          if (r_q.bit_cnt == r_q.len - 5'h01) begin
            r_d.st       = ST_CMD;
            r_d.bit_cnt  = 5'h00;
            r_d.wr_pulse = 1'b1;
            if (r_q.rs == RS_MODE) begin
              r_d.cfg.mode = {r_q.shreg[14:0], din_s};
            end else begin
              r_d.cfg.filter = {r_q.shreg[6:0], din_s};
            end
          end
        end
        ST_READ: begin
          r_d.bit_cnt = r_q.bit_cnt + 5'h01;
          if (r_q.bit_cnt == r_q.len - 5'h01) begin
            r_d.st      = ST_CMD;
            r_d.bit_cnt = 5'h00;
            if (r_q.rs == RS_DATA) begin
              r_d.rd_done = 1'b1;
              r_d.ready   = 1'b0;
            end
          end
        end
      endcase

      if (din_s && r_q.ones == ONES_RESET - 6'h01) begin
        r_d.st       = ST_CMD;
        r_d.bit_cnt  = 5'h00;
        r_d.cfg.mode = MODE_RST;
        r_d.cfg.filter = FILTER_RST;
        r_d.data     = DATA_RST;
        r_d.ready    = 1'b0;
        r_d.part_rst = 1'b1;
      end
    end else if (fall && r_q.st == ST_READ) begin
      r_d.dout  = r_q.shreg[23];
      r_d.shreg = {r_q.shreg[22:0], 1'b0};
    end

    // A new result wins over a clear in the same cycle
    if (ready_set) begin
      r_d.ready = 1'b1;
    end

    // Outside a read the line shows ready, active low, so a result gives a falling edge
    if (r_d.st != ST_READ) begin
      r_d.dout = !r_d.ready;
    end
    r_d.oe_n = !sel;
  end

  always_ff @(posedge clock or negedge rst_b_q) begin
    if (!rst_b_q) begin
      r_q <= '{st: ST_CMD, bit_cnt: 5'h00, len: LEN_CMD, shreg: 24'h000000,
               ones: 6'h00, rs: RS_STATUS, sclk_prev: 1'b1, ready: 1'b0,
               data: DATA_RST, dout: 1'b1, oe_n: 1'b1,
               cfg: '{mode: MODE_RST, filter: FILTER_RST},
               wr_pulse: 1'b0, rd_done: 1'b0, part_rst: 1'b0};
    end else begin
      r_q <= r_d;
    end
  end

  assign dout       = r_q.dout;
  assign dout_oe_n  = r_q.oe_n;
  assign ready      = r_q.ready;
  assign cfg        = r_q.cfg;
  assign cfg_wr     = r_q.wr_pulse;
  assign data_read  = r_q.rd_done;
  assign part_reset = r_q.part_rst;

endmodule : asp_serial_port

// ### src/asp_pkg.sv
// Shared constants and carrier types for the converter serial port.
// Assumes one system clock domain; the serial pins are asynchronous to it.
package asp_pkg;

  // Command byte field positions, first bit received is bit 7
  localparam int CMD_GATE_BIT = 7;
  localparam int CMD_RS_HI    = 5;
  localparam int CMD_RS_LO    = 4;
  localparam int CMD_DIR_BIT  = 3;

  // Register select codes
  localparam logic [1:0] RS_STATUS = 2'h0;
  localparam logic [1:0] RS_MODE   = 2'h1;
  localparam logic [1:0] RS_FILTER = 2'h2;
  localparam logic [1:0] RS_DATA   = 2'h3;

  // Transfer lengths in bits
  localparam logic [4:0] LEN_CMD    = 5'h08;
  localparam logic [4:0] LEN_STATUS = 5'h08;
  localparam logic [4:0] LEN_MODE   = 5'h10;
  localparam logic [4:0] LEN_FILTER = 5'h08;
  localparam logic [4:0] LEN_DATA   = 5'h18;

  // Run of ones on the serial input that resets the whole part
  localparam logic [5:0] ONES_RESET = 6'h20;

  // Reset values
  localparam logic [15:0] MODE_RST   = 16'h0000;
  localparam logic [7:0]  FILTER_RST = 8'h00;
  localparam logic [23:0] DATA_RST   = 24'h000000;

  // Status byte layout
  localparam int STAT_READY_BIT = 7;

  typedef enum logic [1:0] {
    ST_CMD,
    ST_WRITE,
    ST_READ
  } asp_state_t;

  typedef struct packed {
    logic [15:0] mode;
    logic [7:0]  filter;
  } asp_cfg_t;

  typedef struct packed {
    asp_state_t  st;
    logic [4:0]  bit_cnt;
    logic [4:0]  len;
    logic [23:0] shreg;
    logic [5:0]  ones;
    logic [1:0]  rs;
    logic        sclk_prev;
    logic        ready;
    logic [23:0] data;
    logic        dout;
    logic        oe_n;
    asp_cfg_t    cfg;
    logic        wr_pulse;
    logic        rd_done;
    logic        part_rst;
  } asp_regs_t;

endpackage : asp_pkg

// ### src/asp_sync.sv
// Two-flop synchroniser for a single asynchronous level.
// Assumes the destination clock and an already synchronised reset.
`timescale 1ns/100ps
module asp_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_q   <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : asp_sync

// ### tb/asp_serial_port_chk.sv
// Checker for the converter serial port outputs.
// Sees only the top module ports; bound after the module.
`timescale 1ns/100ps
module asp_serial_port_chk
  import asp_pkg::*;
(
  input wire logic     clock,
  input wire logic     rst_n,
  input wire logic     cs_n,
  input wire logic     conv_valid,
  input wire logic     dout_oe_n,
  input wire logic     ready,
  input wire asp_cfg_t cfg,
  input wire logic     cfg_wr,
  input wire logic     data_read,
  input wire logic     part_reset
);
  import asp_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  chk_oe_release: assert property (cs_n[*5] |-> dout_oe_n)
    else $error("line driven while deselected");
  chk_oe_drive: assert property (!cs_n[*8] |-> !dout_oe_n)
    else $error("line not driven while selected");
  chk_ready_set: assert property (conv_valid |=> ready)
    else $error("ready flag not set");
  chk_ready_cause: assert property ($fell(ready)
    |-> data_read || part_reset || $past(data_read) || $past(part_reset))
    else $error("ready flag dropped without cause");
  chk_read_clears: assert property (data_read && !conv_valid && !$past(conv_valid)
    |-> ##[0:1] !ready)
    else $error("ready flag kept after full read");
  chk_cfg_cause: assert property ($changed(cfg)
    |-> ##[0:1] (cfg_wr || part_reset || $past(part_reset)))
    else $error("config changed without write");
  chk_full_reset: assert property (part_reset |-> ##[0:1] (cfg == '0 && !ready))
    else $error("part reset left state");
  chk_quiet_desel: assert property (cs_n[*8] |-> !data_read && !cfg_wr)
    else $error("transfer completed while deselected");
  cov_read: cover property (data_read);
  cov_write: cover property (cfg_wr);
  cov_reset: cover property (part_reset);
endmodule : asp_serial_port_chk
bind asp_serial_port asp_serial_port_chk i_chk (.clock(clock), .rst_n(rst_n), .cs_n(cs_n),
  .conv_valid(conv_valid), .dout_oe_n(dout_oe_n), .ready(ready), .cfg(cfg),
  .cfg_wr(cfg_wr), .data_read(data_read), .part_reset(part_reset));

// ### tb/asp_host.sv
// Host model: drives serial clock, select and input, samples the shared line.
// The line has no pull; released, it reads as the inverse of its last value.
`timescale 1ns/100ps
module asp_host (
  output logic      sclk,
  output logic      cs_n,
  output logic      din,
  input  wire logic dout,
  input  wire logic dout_oe_n
);
  logic last;
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din  = 1'b1;
    last = 1'b1;
  end
  task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
    rx = '0;
    for (int i = n - 1; i >= 0; i--) begin
      sclk = 1'b0;
      din  = tx[i];
      #40;
      sclk = 1'b1;
      last = dout_oe_n ? ~last : dout;
      rx   = {rx[30:0], last};
      #40;
    end
  endtask : xfer
  // Select is driven only from here, so the pin has a single owner
  task automatic set_cs(input logic v);
    cs_n = v;
  endtask : set_cs
endmodule : asp_host

// ### tb/tb_top.sv
// Self-checking bench for the converter serial port.
// Assumes the host model owns the serial clock, select and input pins.
`timescale 1ns/100ps
module tb_top;
  import asp_pkg::*;
  typedef struct packed {
    logic [15:0] c;
    logic [4:0]  cn;
    logic [15:0] v;
    logic [4:0]  vn;
    asp_cfg_t    e;
  } asp_row_t;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        conv_valid = 1'b0;
  logic [23:0] conv_result = 24'h000000;
  logic        sclk, cs_n, din, dout, dout_oe_n, ready, cfg_wr, data_read, part_reset;
  logic        seen_pr = 1'b0;
  asp_cfg_t    cfg;
  logic [31:0] rx;
  int          fails = 0, n_compared = 0, cycles = 0, n_wr = 0, n_rd = 0;
  asp_row_t    rows [3] = '{{16'h0010, 5'h08, 16'ha5c3, 5'h10, 24'ha5c300},
    {16'h0020, 5'h08, 16'h005a, 5'h08, 24'ha5c35a},
    {16'h0710, 5'h0b, 16'h3c0f, 5'h10, 24'h3c0f5a}};
  asp_serial_port i_dut (.clock(clock), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .din(din),
    .conv_valid(conv_valid), .conv_result(conv_result), .dout(dout), .dout_oe_n(dout_oe_n),
    .ready(ready), .cfg(cfg), .cfg_wr(cfg_wr), .data_read(data_read), .part_reset(part_reset));
  asp_host i_host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout), .dout_oe_n(dout_oe_n));
  always #2.5 clock = ~clock;
  task automatic stop_test();
    $display("compared %0d, failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (part_reset === 1'b1) seen_pr <= 1'b1;
    if (cfg_wr === 1'b1) n_wr <= n_wr + 1;
    if (data_read === 1'b1) n_rd <= n_rd + 1;
    if (cycles == 20000) begin
      fails = fails + 1;
      stop_test();
    end
  end
  task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : idle
  task automatic conv(input logic [23:0] r);
    idle(1);
    conv_valid = 1'b1;
    conv_result = r;
    idle(1);
    conv_valid = 1'b0;
  endtask : conv
  task automatic rd(input logic [7:0] c, input int n);
    i_host.xfer({24'h0, c}, 8, rx);
    i_host.xfer(32'h0, n, rx);
  endtask : rd
  initial begin
    idle(6);
    rst_n = 1'b1;
    idle(8);
    cmp({dout, dout_oe_n, ready}, 3'b110);
    cmp(cfg, 24'h0);
    $display("test reset done");
    // Select stays low over all rows: three-wire use, back to back
    i_host.set_cs(1'b0);
    foreach (rows[k]) begin
      i_host.xfer({16'h0, rows[k].c}, rows[k].cn, rx);
      #500;
      i_host.xfer({16'h0, rows[k].v}, rows[k].vn, rx);
      idle(4);
      cmp(cfg, rows[k].e);
    end
    cmp(24'(n_wr), 24'h000003);
    // A write to the data address has no data phase; the next byte is a command
    i_host.xfer(32'h30, 8, rx);
    rd(8'h18, 16);
    cmp(rx[15:0], 16'h3c0f);
    rd(8'h28, 8);
    cmp(rx[7:0], 8'h5a);
    cmp(24'(n_wr), 24'h000003);
    $display("test writes done");
    conv(24'h9a5c33);
    idle(3);
    cmp({dout, dout_oe_n, ready}, 3'b001);
    rd(8'h08, 8);
    cmp(rx[7:0], 8'h80);
    rd(8'h38, 24);
    cmp(rx[23:0], 24'h9a5c33);
    idle(2);
    cmp({dout, ready}, 2'b10);
    cmp(24'(n_rd), 24'h000001);
    $display("test ready done");
    i_host.set_cs(1'b1);
    conv(24'h31c2a7);
    idle(6);
    cmp({dout_oe_n, ready}, 2'b11);
    i_host.set_cs(1'b0);
    i_host.xfer(32'h3, 4, rx);
    i_host.set_cs(1'b1);
    idle(6);
    i_host.set_cs(1'b0);
    rd(8'h38, 24);
    cmp(rx[23:0], 24'h31c2a7);
    cmp(24'(n_rd), 24'h000002);
    $display("test select done");
    conv(24'h000001);
    i_host.xfer(32'hffffffff, 32, rx);
    idle(4);
    cmp({seen_pr, ready}, 2'b10);
    cmp(cfg, 24'h0);
    $display("test ones done");
    // Command and data in one unbroken train, then a reset with select held low
    i_host.xfer(32'h0010a5c3, 24, rx);
    idle(4);
    cmp(cfg, 24'ha5c300);
    rst_n = 1'b0;
    idle(2);
    rst_n = 1'b1;
    idle(8);
    cmp({dout, dout_oe_n, ready}, 3'b100);
    cmp(cfg, 24'h0);
    $display("test mid reset done");
    stop_test();
  end
endmodule : tb_top
